/* File: design/tmp_pkg.sv */
// Package with constants and carrier types of the tag memory partition and hide logic.
// ****************************************************************************
// ****************************************************************************
package tmp_pkg;

  // ****************************************************************************
  // Memory layout.
  // ****************************************************************************
  localparam int unsigned BLOCK_BITS       = 64;
  localparam int unsigned TOTAL_BLOCKS     = 10;
  localparam int unsigned EPC_BASE_BITS    = 128;
  localparam int unsigned EPC_MAX_EXTRA    = 5;
  localparam int unsigned USER_PWD_BITS    = 32;
  localparam logic [11:0] PART_WORD_ADDR   = 12'h1f0;
  localparam logic [11:0] FEAT_WORD_ADDR   = 12'h200;
  localparam logic [15:0] PART_WORD_RESET  = 16'h0000;
  // Field positions are word bit indexes counted from the LSB, bit 0 is word bit 0.
  localparam int unsigned PART_EPC_LSB     = 8;
  localparam int unsigned PART_PROT_LSB    = 4;
  localparam int unsigned PART_PRIV_LSB    = 0;
  localparam logic [15:0] PART_RFU_MASK    = 16'hf000;
  localparam int unsigned FEAT_EPC_HIDE    = 2;
  localparam int unsigned FEAT_TID_HIDE    = 1;

  // ****************************************************************************
  // Command code, CRC-16 constants and error codes.
  // ****************************************************************************
  localparam logic [15:0] CMD_HIDE         = 16'he001;
  localparam logic [15:0] CRC16_RESIDUE    = 16'h1d0f;
  localparam logic [15:0] CRC16_PRESET     = 16'hffff;
  localparam logic [15:0] CRC16_POLY       = 16'h1021;
  localparam logic [7:0]  ERR_LOCKED_MEM   = 8'h04;
  localparam logic [7:0]  ERR_OTHER        = 8'h00;

  // Air-interface session states as tracked by the surrounding tag core.
  typedef enum logic [2:0] {
    TMP_READY, TMP_ARBITRATE, TMP_REPLY, TMP_ACK, TMP_OPEN, TMP_SECURED, TMP_KILLED
  } tmp_tag_state_t;

  // Segment decode for one user-memory block.
  typedef enum logic [1:0] {
    TMP_SEG_EPC, TMP_SEG_OPEN, TMP_SEG_PROT, TMP_SEG_PRIV
  } tmp_seg_t;

  // Reply kinds handed to the backscatter encoder.
  typedef enum logic [1:0] {
    TMP_RPL_NONE, TMP_RPL_HANDLE, TMP_RPL_ERROR
  } tmp_rpl_kind_t;

  // Bit-serial command stream from the demodulator.
  typedef struct packed {
    logic frame_start;
    logic bit_valid;
    logic bit_data;
    logic frame_end;
  } tmp_rx_t;

  // Reply request to the backscatter encoder.
  typedef struct packed {
    logic          start;
    tmp_rpl_kind_t kind;
    logic          ext_preamble;
    logic [15:0]   handle;
    logic [7:0]    err_code;
  } tmp_tx_t;

  // Partition-word write request from the standard Write path.
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } tmp_pwr_t;

endpackage : tmp_pkg

/* File: design/tmp_partition_hide.sv */
// Partition decode, partition-word storage and hide command handling of the tag.
`timescale 1ns/10ps
module tmp_partition_hide (
  input  wire logic                    clock_i,        // System clock, 25 MHz.
  input  wire logic                    reset_i,        // Asynchronous reset, high.
  input  wire tmp_pkg::tmp_tag_state_t tag_state_i,    // Current session state.
  input  wire logic [15:0]             handle_i,       // Current handle.
  input  wire logic [31:0]             access_pwd_i,   // Stored access password.
  input  wire tmp_pkg::tmp_rx_t        rx_i,           // Demodulated command bits.
  input  wire tmp_pkg::tmp_pwr_t       part_wr_i,      // Standard Write to 1F0h.
  input  wire logic                    unhide_i,       // Valid unhide pulse.
  input  wire logic                    any_lock_i,     // A memory lock took place.
  input  wire logic                    nvm_fail_i,     // Flag store failed.
  input  wire logic [3:0]              blk_sel_i,      // User block to classify.
  output tmp_pkg::tmp_seg_t            blk_seg_o,      // Segment of that block.
  output logic                         blk_visible_o,  // Block exists for caller.
  output logic [15:0]                  part_word_o,    // Word for Read and Select.
  output logic                         part_wr_ok_o,   // Write accepted pulse.
  output logic                         part_wr_err_o,  // Write rejected pulse.
  output logic [9:0]                   epc_bits_o,     // EPC length in bits.
  output logic [3:0]                   open_blocks_o,  // Open segment blocks.
  output logic [11:0]                  user_pwd_addr_o,// User password bit address.
  output logic                         epc_hide_o,     // EPC hide flag.
  output logic                         tid_hide_o,     // TID hide flag.
  output logic                         go_arbitrate_o, // Request move to arbitrate.
  output tmp_pkg::tmp_tx_t             tx_o            // Reply request.
);

  // ****************************************************************************
  // State.
  // ****************************************************************************
  typedef struct packed {
    logic [15:0] part;
    logic        part_locked;
    logic        epc_hide;
    logic        tid_hide;
    logic [5:0]  nbits;
    logic [15:0] code;
    logic [15:0] hnd;
    logic [15:0] crc;
    logic        wr_ok;
    logic        wr_err;
    logic        go_arb;
    tmp_pkg::tmp_tx_t tx;
  } tmp_state_t;

  tmp_state_t st_r;
  tmp_state_t st_nxt;

  logic [3:0] epc_x;
  logic [3:0] prot_n;
  logic [3:0] priv_n;
  logic [4:0] used;
  logic [3:0] w_epc;
  logic [3:0] w_prot;
  logic [3:0] w_priv;
  logic [4:0] w_used;
  logic       secured;
  logic [3:0] pwd_blk;

  // Fields of the stored word; layout is MSB-first on the air.
  assign epc_x   = st_r.part[tmp_pkg::PART_EPC_LSB +: 4];
  assign prot_n  = st_r.part[tmp_pkg::PART_PROT_LSB +: 4];
  assign priv_n  = st_r.part[tmp_pkg::PART_PRIV_LSB +: 4];
  assign used    = {1'b0, epc_x} + {1'b0, prot_n} + {1'b0, priv_n};
  assign w_epc   = part_wr_i.data[tmp_pkg::PART_EPC_LSB +: 4];
  assign w_prot  = part_wr_i.data[tmp_pkg::PART_PROT_LSB +: 4];
  assign w_priv  = part_wr_i.data[tmp_pkg::PART_PRIV_LSB +: 4];
  assign w_used  = {1'b0, w_epc} + {1'b0, w_prot} + {1'b0, w_priv};
  assign secured = (tag_state_i == tmp_pkg::TMP_SECURED);

  // ****************************************************************************
  // Layout decode.
  // ****************************************************************************
  // Blocks run EPC extension, open, protected, private; private ends the memory.
  always_comb begin
    logic [4:0] b;
    b = {1'b0, blk_sel_i};
    if (b < {1'b0, epc_x}) begin
      blk_seg_o = tmp_pkg::TMP_SEG_EPC;
    end else if (b >= 5'(tmp_pkg::TOTAL_BLOCKS) - {1'b0, priv_n}) begin
      blk_seg_o = tmp_pkg::TMP_SEG_PRIV;
    end else if (b >= 5'(tmp_pkg::TOTAL_BLOCKS) - {1'b0, priv_n} - {1'b0, prot_n}) begin
      blk_seg_o = tmp_pkg::TMP_SEG_PROT;
    end else begin
      blk_seg_o = tmp_pkg::TMP_SEG_OPEN;
    end
  end

  // Private blocks vanish for callers outside the secured state.
  assign blk_visible_o   = (blk_sel_i < 4'(tmp_pkg::TOTAL_BLOCKS)) &&
                           ((blk_seg_o != tmp_pkg::TMP_SEG_PRIV) || secured);
  assign epc_bits_o      = 10'(tmp_pkg::EPC_BASE_BITS) + 10'({epc_x, 6'h00});
  assign open_blocks_o   = 4'(5'(tmp_pkg::TOTAL_BLOCKS) - used);
  // Blocks left to user memory, times 64 as a shift so no narrow product can overflow.
  assign pwd_blk         = 4'(tmp_pkg::TOTAL_BLOCKS) - epc_x;
  assign user_pwd_addr_o = {2'b00, pwd_blk, 6'h00};
  assign part_word_o     = st_r.part & ~tmp_pkg::PART_RFU_MASK;
  assign part_wr_ok_o    = st_r.wr_ok;
  assign part_wr_err_o   = st_r.wr_err;
  assign epc_hide_o      = st_r.epc_hide;
  assign tid_hide_o      = st_r.tid_hide;
  assign go_arbitrate_o  = st_r.go_arb;
  assign tx_o            = st_r.tx;

  // ****************************************************************************
  // CRC step.
  // ****************************************************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
    logic fb;
    fb = c[15] ^ d;
    crc_step = {c[14:0], 1'b0} ^ (fb ? tmp_pkg::CRC16_POLY : 16'h0000);
  endfunction : crc_step

  // ****************************************************************************
  // Next state.
  // ****************************************************************************
  // Commands are 48 bits; anything longer or shorter is not the hide command.
  always_comb begin
    logic good;
    st_nxt        = st_r;
    st_nxt.wr_ok  = 1'b0;
    st_nxt.wr_err = 1'b0;
    st_nxt.go_arb = 1'b0;
    st_nxt.tx     = '0;
    good          = 1'b0;

    // Partition word write: once, secured, at most ten blocks.
    if (part_wr_i.wr) begin
      if (st_r.part_locked || !secured || w_used > 5'(tmp_pkg::TOTAL_BLOCKS) ||
          w_epc > 4'(tmp_pkg::EPC_MAX_EXTRA)) begin
        st_nxt.wr_err = 1'b1;
      end else begin
        st_nxt.part        = part_wr_i.data & ~tmp_pkg::PART_RFU_MASK;
        st_nxt.part_locked = 1'b1;
        st_nxt.wr_ok       = 1'b1;
      end
    end
    if (any_lock_i) begin
      st_nxt.part_locked = 1'b1;
    end

    // Shift command bits and run CRC over all of them.
    if (rx_i.frame_start) begin
      st_nxt.nbits = '0;
      st_nxt.crc   = tmp_pkg::CRC16_PRESET;
    end else if (rx_i.bit_valid) begin
      st_nxt.crc = crc_step(st_r.crc, rx_i.bit_data);
      if (st_r.nbits < 6'd16) begin
        st_nxt.code = {st_r.code[14:0], rx_i.bit_data};
      end else if (st_r.nbits < 6'd32) begin
        st_nxt.hnd = {st_r.hnd[14:0], rx_i.bit_data};
      end
      if (st_r.nbits != 6'h3f) begin
        st_nxt.nbits = st_r.nbits + 6'd1;
      end
    end

    if (rx_i.frame_end && st_r.nbits == 6'd48 && st_r.code == tmp_pkg::CMD_HIDE &&
        st_r.crc == tmp_pkg::CRC16_RESIDUE) begin
      good = 1'b1;
    end

    if (good) begin
      case (tag_state_i)
        tmp_pkg::TMP_ARBITRATE, tmp_pkg::TMP_REPLY, tmp_pkg::TMP_ACK: begin
          st_nxt.go_arb = 1'b1;
        end
        tmp_pkg::TMP_SECURED: begin
          if (st_r.hnd != handle_i) begin
            st_nxt.go_arb = 1'b0;                               // Silent, stays secured.
          end else if (access_pwd_i == 32'h0000_0000) begin
            st_nxt.go_arb = 1'b1;
          end else if (nvm_fail_i) begin
            st_nxt.tx.start    = 1'b1;
            st_nxt.tx.kind     = tmp_pkg::TMP_RPL_ERROR;
            st_nxt.tx.err_code = tmp_pkg::ERR_OTHER;
            st_nxt.tx.ext_preamble = 1'b1;
          end else begin
            st_nxt.epc_hide        = 1'b1;
            st_nxt.tid_hide        = 1'b1;
            st_nxt.tx.start        = 1'b1;
            st_nxt.tx.kind         = tmp_pkg::TMP_RPL_HANDLE;
            st_nxt.tx.handle       = handle_i;
            st_nxt.tx.ext_preamble = 1'b1;
          end
        end
        default: begin
          st_nxt.go_arb = 1'b0;                                 // Ready, open, killed.
        end
      endcase
    end

    // Unhide clears unless a successful hide lands in the same cycle; the set wins.
    if (unhide_i && !(st_nxt.tx.start && st_nxt.tx.kind == tmp_pkg::TMP_RPL_HANDLE)) begin
      st_nxt.epc_hide = 1'b0;
      st_nxt.tid_hide = 1'b0;
    end
  end

  // State register; flags held in nonvolatile store restart cleared here.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_r      <= '0;
      st_r.part <= tmp_pkg::PART_WORD_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************************
  // Checks.
  // ****************************************************************************
  chk_hide_sets: assert property (@(posedge clock_i) disable iff (reset_i)
    (tx_o.start && tx_o.kind == tmp_pkg::TMP_RPL_HANDLE) |-> (epc_hide_o && tid_hide_o))
    else $error("Hide reply without flags set.");
  chk_ext_preamble: assert property (@(posedge clock_i) disable iff (reset_i)
    tx_o.start |-> tx_o.ext_preamble)
    else $error("Reply without extended preamble.");
  chk_handle_echo: assert property (@(posedge clock_i) disable iff (reset_i)
    (tx_o.start && tx_o.kind == tmp_pkg::TMP_RPL_HANDLE) |-> tx_o.handle == $past(handle_i))
    else $error("Reply handle mismatch.");
  chk_zero_pwd: assert property (@(posedge clock_i) disable iff (reset_i)
    ($past(access_pwd_i) == 32'h0) |-> !tx_o.start)
    else $error("Reply with zero access password.");
  chk_once_only: assert property (@(posedge clock_i) disable iff (reset_i)
    $past(st_r.part_locked) |-> !part_wr_ok_o)
    else $error("Partition word written twice.");
  chk_over_ten: assert property (@(posedge clock_i) disable iff (reset_i)
    (part_wr_i.wr && w_used > 5'd10) |=> part_wr_err_o)
    else $error("Oversized layout accepted.");
  chk_rfu_zero: assert property (@(posedge clock_i) disable iff (reset_i)
    part_word_o[15:12] == 4'h0)
    else $error("Reserved bits not zero.");
  chk_open_size: assert property (@(posedge clock_i) disable iff (reset_i)
    (open_blocks_o + epc_x + prot_n + priv_n) == 4'd10)
    else $error("Blocks do not sum to ten.");
  chk_private_hidden: assert property (@(posedge clock_i) disable iff (reset_i)
    (blk_seg_o == tmp_pkg::TMP_SEG_PRIV && !secured) |-> !blk_visible_o)
    else $error("Private block visible.");
  chk_lock_follows: assert property (@(posedge clock_i) disable iff (reset_i)
    any_lock_i |=> st_r.part_locked)
    else $error("Partition word not locked.");

  cov_hide_ok: cover property (@(posedge clock_i) disable iff (reset_i)
    tx_o.start && tx_o.kind == tmp_pkg::TMP_RPL_HANDLE);
  cov_hide_err: cover property (@(posedge clock_i) disable iff (reset_i)
    tx_o.start && tx_o.kind == tmp_pkg::TMP_RPL_ERROR);
  cov_part_ok: cover property (@(posedge clock_i) disable iff (reset_i) part_wr_ok_o);
  cov_arb: cover property (@(posedge clock_i) disable iff (reset_i) go_arbitrate_o);

endmodule : tmp_partition_hide

/* File: verification/tmp_reader_model.sv */
// Interrogator model that frames hide commands onto the demodulated bit stream.
`timescale 1ns/10ps
module tmp_reader_model (
  input  wire logic        clock_i, // System clock.
  output tmp_pkg::tmp_rx_t rx_o     // Demodulated command bits.
);
  // Idle stream at time zero.
  initial begin
    rx_o = '0;
  end

  // Sends code, handle and inverted CRC-16 MSB first; bad_crc flips the last bit.
  task automatic send_hide(input logic [15:0] handle, input logic bad_crc);
    logic [47:0] frame;
    logic [15:0] crc;
    logic        fb;
    crc   = tmp_pkg::CRC16_PRESET;
    frame = {tmp_pkg::CMD_HIDE, handle, 16'h0000};
    for (int i = 47; i >= 16; i--) begin
      fb  = crc[15] ^ frame[i];
      crc = {crc[14:0], 1'b0} ^ (fb ? tmp_pkg::CRC16_POLY : 16'h0000);
    end
    frame[15:0] = ~crc ^ {15'h0000, bad_crc};
    @(posedge clock_i);
    #1;
    rx_o.frame_start = 1'b1;
    for (int i = 47; i >= 0; i--) begin
      @(posedge clock_i);
      #1;
      rx_o.frame_start = 1'b0;
      rx_o.bit_valid   = 1'b1;
      rx_o.bit_data    = frame[i];
    end
    @(posedge clock_i);
    #1;
    rx_o.bit_valid = 1'b0;
    rx_o.bit_data  = ~rx_o.bit_data; // Stale data is never left on the line.
    rx_o.frame_end = 1'b1;
    @(posedge clock_i);
    #1;
    rx_o.frame_end = 1'b0;
    // Carrier is held while the reply is awaited, well short of the time limit.
    repeat (4) @(posedge clock_i);
  endtask : send_hide
endmodule : tmp_reader_model

/* File: verification/tmp_partition_hide_tb_top.sv */
// Self-checking bench for partition decode and hide command handling.
`timescale 1ns/10ps
module tmp_partition_hide_tb_top;
  localparam logic [15:0] HND = 16'h5a3c;
  localparam logic [31:0] PWD = 32'h1234_5678;
  logic                    clock_i, reset_i, unhide_i, any_lock_i, nvm_fail_i;
  tmp_pkg::tmp_tag_state_t tag_state_i;
  logic [31:0]             access_pwd_i;
  tmp_pkg::tmp_rx_t        rx_i;
  tmp_pkg::tmp_pwr_t       part_wr_i;
  logic [3:0]              blk_sel_i, open_blocks_o;
  tmp_pkg::tmp_seg_t       blk_seg_o, exp_seg;
  logic                    blk_visible_o, part_wr_ok_o, part_wr_err_o;
  logic                    epc_hide_o, tid_hide_o, go_arbitrate_o;
  logic [15:0]             part_word_o, tx_seen, arb_seen;
  logic [9:0]              epc_bits_o;
  logic [11:0]             user_pwd_addr_o;
  tmp_pkg::tmp_tx_t        tx_o, tx_cap;
  int                      fail_count, checks;
  tmp_pkg::tmp_tag_state_t sl [6] = '{tmp_pkg::TMP_READY, tmp_pkg::TMP_ARBITRATE,
    tmp_pkg::TMP_REPLY, tmp_pkg::TMP_ACK, tmp_pkg::TMP_OPEN, tmp_pkg::TMP_KILLED};

  tmp_partition_hide tmp_partition_hide_inst (.clock_i(clock_i), .reset_i(reset_i),
    .tag_state_i(tag_state_i), .handle_i(HND), .access_pwd_i(access_pwd_i), .rx_i(rx_i),
    .part_wr_i(part_wr_i), .unhide_i(unhide_i), .any_lock_i(any_lock_i),
    .nvm_fail_i(nvm_fail_i), .blk_sel_i(blk_sel_i), .blk_seg_o(blk_seg_o),
    .blk_visible_o(blk_visible_o), .part_word_o(part_word_o), .part_wr_ok_o(part_wr_ok_o),
    .part_wr_err_o(part_wr_err_o), .epc_bits_o(epc_bits_o), .open_blocks_o(open_blocks_o),
    .user_pwd_addr_o(user_pwd_addr_o), .epc_hide_o(epc_hide_o), .tid_hide_o(tid_hide_o),
    .go_arbitrate_o(go_arbitrate_o), .tx_o(tx_o));
  tmp_reader_model tmp_reader_model_inst (.clock_i(clock_i), .rx_o(rx_i));

  // Free-running 25 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Counts one-cycle answer pulses so none is missed between polls.
  always @(posedge clock_i) begin
    if (tx_o.start === 1'b1) begin
      tx_seen <= tx_seen + 16'h0001;
      tx_cap  <= tx_o;
    end
    if (go_arbitrate_o === 1'b1) begin
      arb_seen <= arb_seen + 16'h0001;
    end
  end

  // Counts and reports one comparison.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One partition write; the answer pulse is looked at in the cycle it stands.
  task automatic pw(input logic [15:0] d, input logic ok);
    @(posedge clock_i);
    #1;
    part_wr_i.data = d;
    part_wr_i.wr   = 1'b1;
    @(posedge clock_i);
    #1;
    part_wr_i.wr = 1'b0;
    chk("wr_ok", 16'(ok), 16'(part_wr_ok_o));
    chk("wr_err", 16'(!ok), 16'(part_wr_err_o));
  endtask : pw

  // One hide frame under the given conditions, then the answer and flags.
  task automatic hide(input tmp_pkg::tmp_tag_state_t s, input logic [15:0] h,
                      input logic [31:0] p, input logic bad, input logic nf,
                      input logic etx, input logic earb, input logic efl);
    tag_state_i  = s;
    access_pwd_i = p;
    nvm_fail_i   = nf;
    tx_seen      = 16'h0000;
    arb_seen     = 16'h0000;
    tmp_reader_model_inst.send_hide(h, bad);
    #1;
    chk("tx_start", 16'(etx), tx_seen);
    chk("go_arb", 16'(earb), arb_seen);
    chk("epc_hide", 16'(efl), 16'(epc_hide_o));
    chk("tid_hide", 16'(efl), 16'(tid_hide_o));
  endtask : hide

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // Watchdog that cuts a hang short.
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    reset_i = 1'b1;
    tag_state_i = tmp_pkg::TMP_READY;
    access_pwd_i = PWD;
    part_wr_i = '0;
    {unhide_i, any_lock_i, nvm_fail_i} = 3'h0;
    blk_sel_i = 4'h0;
    repeat (10) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    chk("part_word", 16'h0000, part_word_o);
    chk("epc_bits", 16'h0080, 16'(epc_bits_o));
    chk("open_blocks", 16'h000a, 16'(open_blocks_o));
    chk("pwd_addr", 16'h0280, 16'(user_pwd_addr_o));
    pw(16'h0106, 1'b0);
    tag_state_i = tmp_pkg::TMP_SECURED;
    pw(16'h0156, 1'b0);
    pw(16'h0600, 1'b0);
    pw(16'hf106, 1'b1);
    chk("part_word", 16'h0106, part_word_o);
    chk("epc_bits", 16'h00c0, 16'(epc_bits_o));
    chk("open_blocks", 16'h0003, 16'(open_blocks_o));
    chk("pwd_addr", 16'h0240, 16'(user_pwd_addr_o));
    for (int b = 0; b < 10; b++) begin
      blk_sel_i = 4'(b);
      exp_seg = (b == 0) ? tmp_pkg::TMP_SEG_EPC : (b < 4) ? tmp_pkg::TMP_SEG_OPEN
              : tmp_pkg::TMP_SEG_PRIV;
      #1;
      chk("blk_seg", 16'(exp_seg), 16'(blk_seg_o));
      chk("blk_visible", 16'h0001, 16'(blk_visible_o));
    end
    tag_state_i = tmp_pkg::TMP_OPEN;
    #1;
    chk("priv_visible", 16'h0000, 16'(blk_visible_o));
    tag_state_i = tmp_pkg::TMP_SECURED;
    pw(16'h0043, 1'b0);
    for (int i = 0; i < 6; i++) begin
      hide(sl[i], HND, PWD, 1'b0, 1'b0, 1'b0, (i >= 1 && i <= 3), 1'b0);
    end
    hide(tmp_pkg::TMP_SECURED, HND, 32'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    hide(tmp_pkg::TMP_SECURED, ~HND, PWD, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    hide(tmp_pkg::TMP_SECURED, HND, PWD, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    hide(tmp_pkg::TMP_SECURED, HND, PWD, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk("rpl_kind", 16'(tmp_pkg::TMP_RPL_ERROR), 16'(tx_cap.kind));
    chk("rpl_err", 16'(tmp_pkg::ERR_OTHER), 16'(tx_cap.err_code));
    hide(tmp_pkg::TMP_SECURED, HND, PWD, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("rpl_kind", 16'(tmp_pkg::TMP_RPL_HANDLE), 16'(tx_cap.kind));
    chk("rpl_handle", HND, tx_cap.handle);
    chk("rpl_ext", 16'h0001, 16'(tx_cap.ext_preamble));
    unhide_i = 1'b1;
    @(posedge clock_i);
    #1;
    unhide_i = 1'b0;
    @(posedge clock_i);
    #1;
    chk("epc_hide", 16'h0000, 16'(epc_hide_o));
    chk("tid_hide", 16'h0000, 16'(tid_hide_o));
    // A second reset, then a lock elsewhere freezes the unprogrammed word.
    reset_i = 1'b1;
    @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    any_lock_i = 1'b1;
    @(posedge clock_i);
    #1;
    any_lock_i = 1'b0;
    pw(16'h0043, 1'b0);
    chk("part_word", 16'h0000, part_word_o);
    // A third reset, then a three-segment layout: 3 open, 4 protected, 3 private.
    reset_i = 1'b1;
    @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    pw(16'h0043, 1'b1);
    chk("open_blocks", 16'h0003, 16'(open_blocks_o));
    chk("epc_bits", 16'h0080, 16'(epc_bits_o));
    chk("pwd_addr", 16'h0280, 16'(user_pwd_addr_o));
    for (int b = 0; b < 10; b++) begin
      blk_sel_i = 4'(b);
      exp_seg = (b < 3) ? tmp_pkg::TMP_SEG_OPEN : (b < 7) ? tmp_pkg::TMP_SEG_PROT
              : tmp_pkg::TMP_SEG_PRIV;
      #1;
      chk("blk_seg", 16'(exp_seg), 16'(blk_seg_o));
    end
    wrap_up();
  end
endmodule : tmp_partition_hide_tb_top
